/* File: rtl/cpu_regs_pkg.sv */
package cpu_regs_pkg;

	localparam int ccr_mask_bit = 7;
	localparam int ccr_user_hi_bit = 6;
	localparam int ccr_half_bit = 5;
	localparam int ccr_user_lo_bit = 4;
	localparam int ccr_neg_bit = 3;
	localparam int ccr_zero_bit = 2;
	localparam int ccr_ovf_bit = 1;
	localparam int ccr_carry_bit = 0;
	localparam logic [15:0] reset_vector_addr = 16'h0000;
	localparam logic [7:0] ccr_reset_value = 8'h80;
	localparam logic [2:0] stack_reg_index = 3'h7;
	localparam int reg_count = 8;

	typedef enum logic [1:0] {
		op_none = 2'b00,
		op_write = 2'b01,
		op_and = 2'b10,
		op_or = 2'b11
	} ctl_op_t;

	typedef enum logic [3:0] {
		alu_nop = 4'h0,
		alu_add_b = 4'h1,
		alu_addx_b = 4'h2,
		alu_sub_b = 4'h3,
		alu_subx_b = 4'h4,
		alu_cmp_b = 4'h5,
		alu_neg_b = 4'h6,
		alu_add_w = 4'h7,
		alu_sub_w = 4'h8,
		alu_cmp_w = 4'h9,
		alu_daa = 4'ha,
		alu_das = 4'hb,
		alu_logic_b = 4'hc,
		alu_shift_b = 4'hd,
		alu_xor_ccr = 4'he
	} alu_op_t;

	typedef struct packed {
		logic we;
		logic [2:0] idx;
		logic [1:0] lanes;
		logic [15:0] data;
	} reg_write_t;

	typedef struct packed {
		logic [3:0] mask;
		logic [3:0] nzvc;
	} flag_update_t;

	typedef enum logic [1:0] {
		st_vec_req = 2'b00,
		st_vec_wait = 2'b01,
		st_run = 2'b10
	} boot_state_t;

endpackage

/* File: rtl/cpu_alu_flags.sv */
`timescale 1ns/1ps
module cpu_alu_flags
	import cpu_regs_pkg::*;
(
	// operation
	input wire alu_op_t op,
	input wire logic [15:0] a,
	input wire logic [15:0] b,
	input wire logic [7:0] ccr_in,
	// result
	output logic [15:0] result,
	output logic [7:0] ccr_out
);
	logic c_in;
	logic h_in;
	logic [8:0] s8;
	logic [4:0] n8;
	logic [16:0] s16;
	logic [12:0] n16;
	logic [7:0] adj;
	logic dc;

	always_comb begin
		c_in = ccr_in[ccr_carry_bit];
		h_in = ccr_in[ccr_half_bit];
		s8 = '0;
		n8 = '0;
		s16 = '0;
		n16 = '0;
		adj = 8'h00;
		dc = 1'b0;
		result = a;
		ccr_out = ccr_in;
		unique case (op)
			alu_add_b, alu_addx_b: begin
				s8 = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, op == alu_addx_b && c_in};
				n8 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, op == alu_addx_b && c_in};
			end
			alu_sub_b, alu_subx_b, alu_cmp_b, alu_neg_b: begin
				if (op == alu_neg_b) begin
					s8 = 9'h000 - {1'b0, a[7:0]};
					n8 = 5'h00 - {1'b0, a[3:0]};
				end else begin
					s8 = {1'b0, a[7:0]} - {1'b0, b[7:0]} - {8'h00, op == alu_subx_b && c_in};
					n8 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, op == alu_subx_b && c_in};
				end
			end
			alu_add_w: begin
				s16 = {1'b0, a} + {1'b0, b};
				n16 = {1'b0, a[11:0]} + {1'b0, b[11:0]};
			end
			alu_sub_w, alu_cmp_w: begin
				s16 = {1'b0, a} - {1'b0, b};
				n16 = {1'b0, a[11:0]} - {1'b0, b[11:0]};
			end
			default: begin
			end
		endcase
		unique case (op)
			alu_add_b, alu_addx_b, alu_sub_b, alu_subx_b, alu_cmp_b, alu_neg_b: begin
				if (op != alu_cmp_b)
					result = {a[15:8], s8[7:0]};
				ccr_out[ccr_half_bit] = n8[4];
				ccr_out[ccr_neg_bit] = s8[7];
				if (op == alu_addx_b || op == alu_subx_b)
					ccr_out[ccr_zero_bit] = ccr_in[ccr_zero_bit] && s8[7:0] == 8'h00;
				else
					ccr_out[ccr_zero_bit] = s8[7:0] == 8'h00;
				if (op == alu_add_b || op == alu_addx_b)
					ccr_out[ccr_ovf_bit] = (a[7] == b[7]) && (s8[7] != a[7]);
				else if (op == alu_neg_b)
					ccr_out[ccr_ovf_bit] = a[7:0] == 8'h80;
				else
					ccr_out[ccr_ovf_bit] = (a[7] != b[7]) && (s8[7] != a[7]);
				ccr_out[ccr_carry_bit] = s8[8];
			end
			alu_add_w, alu_sub_w, alu_cmp_w: begin
				if (op != alu_cmp_w)
					result = s16[15:0];
				ccr_out[ccr_half_bit] = n16[12];
				ccr_out[ccr_neg_bit] = s16[15];
				ccr_out[ccr_zero_bit] = s16[15:0] == 16'h0000;
				if (op == alu_add_w)
					ccr_out[ccr_ovf_bit] = (a[15] == b[15]) && (s16[15] != a[15]);
				else
					ccr_out[ccr_ovf_bit] = (a[15] != b[15]) && (s16[15] != a[15]);
				ccr_out[ccr_carry_bit] = s16[16];
			end
			alu_daa, alu_das: begin
				if (h_in || a[3:0] > 4'h9)
					adj[3:0] = 4'h6;
				if (c_in || a[7:0] > 8'h99) begin
					adj[7:4] = 4'h6;
					dc = 1'b1;
				end
				if (op == alu_daa)
					result = {a[15:8], a[7:0] + adj};
				else
					result = {a[15:8], a[7:0] - adj};
				ccr_out[ccr_neg_bit] = result[7];
				ccr_out[ccr_zero_bit] = result[7:0] == 8'h00;
				ccr_out[ccr_carry_bit] = op == alu_daa ? dc : c_in;
			end
			alu_shift_b: begin
				result = {a[15:8], a[6:0], 1'b0};
				ccr_out[ccr_neg_bit] = a[6];
				ccr_out[ccr_zero_bit] = a[6:0] == 7'h00;
				ccr_out[ccr_ovf_bit] = 1'b0;
				ccr_out[ccr_carry_bit] = a[7];
			end
			alu_logic_b: begin
				result = {a[15:8], a[7:0] & b[7:0]};
				ccr_out[ccr_neg_bit] = result[7];
				ccr_out[ccr_zero_bit] = result[7:0] == 8'h00;
				ccr_out[ccr_ovf_bit] = 1'b0;
			end
			alu_xor_ccr: begin
				ccr_out = ccr_in ^ b[7:0];
			end
			default: begin
			end
		endcase
	end
endmodule

/* File: rtl/cpu_register_file_flags.sv */
`timescale 1ns/1ps
module cpu_register_file_flags
	import cpu_regs_pkg::*;
#(
	parameter int regs = reg_count
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// general register write and read
	input wire reg_write_t reg_wr,
	input wire logic [2:0] rd_a_idx,
	input wire logic [2:0] rd_b_idx,
	input wire logic rd_b_high,
	// stack pointer adjust
	input wire logic sp_push,
	input wire logic sp_pop,
	// program counter control
	input wire logic pc_advance,
	input wire logic pc_load,
	input wire logic [15:0] pc_target,
	// condition code control
	input wire ctl_op_t ccr_op,
	input wire logic [7:0] ccr_operand,
	input wire logic ccr_pop,
	input wire logic [15:0] ccr_pop_word,
	input wire logic exception_start,
	input wire alu_op_t alu_op,
	input wire logic alu_write,
	input wire logic [2:0] alu_idx,
	input wire logic [15:0] alu_b,
	input wire logic [2:0] bit_sel,
	input wire logic bit_load_carry,
	input wire logic bit_store_carry,
	input wire logic [3:0] branch_cond,
	// memory access
	input wire logic [15:0] mem_addr_in,
	input wire logic mem_word,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_rvalid,
	// outputs
	output logic [15:0] rd_a_word,
	output logic [7:0] rd_b_byte,
	output logic [15:0] stack_pointer,
	output logic [15:0] fetch_addr,
	output logic [15:0] mem_addr,
	output logic mem_req,
	output logic [7:0] condition_code_register,
	output logic [15:0] ccr_push_word,
	output logic irq_masked,
	output logic branch_taken,
	output logic booted
);
	// the stack index and the 3-bit selects only serve eight word registers
	if (regs != 8) begin : g_regs_check
		$error("register file holds exactly eight word registers");
	end

	logic [7:0] high_q [regs];
	logic [7:0] low_q [regs];
	logic [7:0] high_d [regs];
	logic [7:0] low_d [regs];
	logic [15:0] program_counter_q, program_counter_d;
	logic [7:0] ccr_q, ccr_d;
	boot_state_t state_q, state_d;
	logic [15:0] rd_a_q, rd_a_d;
	logic [7:0] rd_b_q, rd_b_d;
	logic [15:0] sp_q, sp_d;
	logic [15:0] fetch_q, fetch_d;
	logic [15:0] maddr_q, maddr_d;
	logic mreq_q, mreq_d;
	logic br_q, br_d;
	logic booted_q;
	logic [15:0] alu_result;
	logic [7:0] alu_ccr;

	function automatic logic [15:0] word_of(input logic [15:0] addr);
		word_of = {addr[15:1], 1'b0};
	endfunction

	function automatic logic eval_cond(input logic [3:0] cond, input logic [7:0] f);
		logic n, z, v, c;
		n = f[ccr_neg_bit];
		z = f[ccr_zero_bit];
		v = f[ccr_ovf_bit];
		c = f[ccr_carry_bit];
		unique case (cond)
			4'h0: eval_cond = 1'b1;
			4'h1: eval_cond = 1'b0;
			4'h2: eval_cond = !(c || z);
			4'h3: eval_cond = c || z;
			4'h4: eval_cond = !c;
			4'h5: eval_cond = c;
			4'h6: eval_cond = !z;
			4'h7: eval_cond = z;
			4'h8: eval_cond = !v;
			4'h9: eval_cond = v;
			4'ha: eval_cond = !n;
			4'hb: eval_cond = n;
			4'hc: eval_cond = n == v;
			4'hd: eval_cond = n != v;
			4'he: eval_cond = !z && (n == v);
			4'hf: eval_cond = z || (n != v);
		endcase
	endfunction

	cpu_alu_flags u_alu (
		.op(alu_op),
		.a({high_q[alu_idx], low_q[alu_idx]}),
		.b(alu_b),
		.ccr_in(ccr_q),
		.result(alu_result),
		.ccr_out(alu_ccr)
	);

	// registers
	always_comb begin
		for (int i = 0; i < regs; i++) begin
			high_d[i] = high_q[i];
			low_d[i] = low_q[i];
		end
		if (reg_wr.we) begin
			if (reg_wr.lanes[1])
				high_d[reg_wr.idx] = reg_wr.data[15:8];
			if (reg_wr.lanes[0])
				low_d[reg_wr.idx] = reg_wr.data[7:0];
		end
		if (alu_write && alu_op != alu_nop && alu_op != alu_xor_ccr) begin
			high_d[alu_idx] = alu_result[15:8];
			low_d[alu_idx] = alu_result[7:0];
		end
		if (bit_store_carry)
			low_d[alu_idx][bit_sel] = ccr_q[ccr_carry_bit];
		if (sp_push)
			{high_d[stack_reg_index], low_d[stack_reg_index]} = word_of({high_q[stack_reg_index],
				low_q[stack_reg_index]}) - 16'h0002;
		else if (sp_pop)
			{high_d[stack_reg_index], low_d[stack_reg_index]} = word_of({high_q[stack_reg_index],
				low_q[stack_reg_index]}) + 16'h0002;
	end

	// no reset: general registers and stack pointer start undefined
	always_ff @(posedge clk) begin
		for (int i = 0; i < regs; i++) begin
			high_q[i] <= high_d[i];
			low_q[i] <= low_d[i];
		end
	end

	// condition codes
	always_comb begin
		ccr_d = ccr_q;
		if (alu_write)
			ccr_d = alu_ccr;
		if (bit_load_carry)
			ccr_d[ccr_carry_bit] = low_q[alu_idx][bit_sel];
		unique case (ccr_op)
			op_write: ccr_d = ccr_operand;
			op_and: ccr_d = ccr_q & ccr_operand;
			op_or: ccr_d = ccr_q | ccr_operand;
			op_none: begin
			end
		endcase
		if (ccr_pop)
			ccr_d = ccr_pop_word[15:8];
		if (exception_start)
			ccr_d[ccr_mask_bit] = 1'b1;
		if (!resetn)
			ccr_d = ccr_reset_value | (ccr_q & ~ccr_reset_value);
	end

	always_ff @(posedge clk) begin
		ccr_q <= ccr_d;
	end

	// boot and program counter
	always_comb begin
		state_d = state_q;
		program_counter_d = program_counter_q;
		mreq_d = 1'b0;
		maddr_d = maddr_q;
		unique case (state_q)
			st_vec_req: begin
				mreq_d = 1'b1;
				maddr_d = reset_vector_addr;
				state_d = st_vec_wait;
			end
			st_vec_wait: begin
				if (mem_rvalid) begin
					program_counter_d = word_of(mem_rdata);
					state_d = st_run;
				end
			end
			st_run: begin
				if (pc_load)
					program_counter_d = word_of(pc_target);
				else if (pc_advance)
					program_counter_d = word_of(program_counter_q) + 16'h0002;
				mreq_d = mem_word || mem_addr_in != 16'h0000;
				maddr_d = mem_word ? word_of(mem_addr_in) : mem_addr_in;
			end
			default: state_d = st_vec_req;
		endcase
		if (!resetn) begin
			state_d = st_vec_req;
			program_counter_d = 16'h0000;
		end
	end

	always_ff @(posedge clk) begin
		state_q <= state_d;
		program_counter_q <= program_counter_d;
		maddr_q <= resetn ? maddr_d : 16'h0000;
		mreq_q <= resetn ? mreq_d : 1'b0;
		// registered so the boot flag leaves a flop like every other output
		booted_q <= state_d == st_run;
	end

	// registered read ports
	always_comb begin
		rd_a_d = {high_q[rd_a_idx], low_q[rd_a_idx]};
		rd_b_d = rd_b_high ? high_q[rd_b_idx] : low_q[rd_b_idx];
		sp_d = {high_q[stack_reg_index], low_q[stack_reg_index]};
		fetch_d = word_of(program_counter_q);
		br_d = resetn && eval_cond(branch_cond, ccr_q);
	end

	always_ff @(posedge clk) begin
		rd_a_q <= rd_a_d;
		rd_b_q <= rd_b_d;
		sp_q <= sp_d;
		fetch_q <= resetn ? fetch_d : 16'h0000;
		br_q <= br_d;
	end

	assign rd_a_word = rd_a_q;
	assign rd_b_byte = rd_b_q;
	assign stack_pointer = sp_q;
	assign fetch_addr = fetch_q;
	assign mem_addr = maddr_q;
	assign mem_req = mreq_q;
	assign condition_code_register = ccr_q;
	assign ccr_push_word = {ccr_q, ccr_q};
	assign irq_masked = ccr_q[ccr_mask_bit];
	assign branch_taken = br_q;
	assign booted = booted_q;

	a_reset_mask: assert property (@(posedge clk) !resetn |=> ccr_q[ccr_mask_bit])
		else $error("mask not set by reset");
	a_exc_mask: assert property (@(posedge clk) disable iff (!resetn)
		exception_start |=> ccr_q[ccr_mask_bit])
		else $error("mask not set on exception");
	a_fetch_even: assert property (@(posedge clk) disable iff (!resetn) !fetch_addr[0])
		else $error("odd fetch address");
	a_word_even: assert property (@(posedge clk) disable iff (!resetn)
		state_q == st_run && mem_word |=> !mem_addr[0])
		else $error("odd word address");
	a_pop_upper: assert property (@(posedge clk) disable iff (!resetn)
		ccr_pop && !exception_start |=> ccr_q == $past(ccr_pop_word[15:8]))
		else $error("ccr not restored from upper byte");
	a_user_bits: assert property (@(posedge clk) disable iff (!resetn)
		ccr_op == op_write && !ccr_pop && !exception_start |=> ccr_q[6] == $past(ccr_operand[6])
		&& ccr_q[4] == $past(ccr_operand[4]))
		else $error("user bits not stored");
	sequence s_vec_req;
		state_q == st_vec_req;
	endsequence
	sequence s_vec_load;
		##1 mem_req && mem_addr == reset_vector_addr;
	endsequence
	a_vec_fetch: assert property (@(posedge clk) disable iff (!resetn) s_vec_req |-> s_vec_load)
		else $error("vector not requested");
	a_zero_flag: assert property (@(posedge clk) disable iff (!resetn)
		alu_write && alu_op == alu_add_w && ccr_op == op_none && !ccr_pop && !bit_load_carry
		|=> ccr_q[ccr_zero_bit] == ($past(alu_result) == 16'h0000))
		else $error("zero flag wrong");
	a_hold_flags: assert property (@(posedge clk) disable iff (!resetn)
		!alu_write && ccr_op == op_none && !ccr_pop && !exception_start && !bit_load_carry
		|=> $stable(ccr_q))
		else $error("flags changed without cause");

	// the vector answer is a single-cycle strobe; the counter must catch it there
	sequence s_vec_answer;
		state_q == st_vec_wait && mem_rvalid;
	endsequence
	a_vec_boot: assert property (@(posedge clk) disable iff (!resetn)
		s_vec_answer |=> booted && program_counter_q == word_of($past(mem_rdata)))
		else $error("vector not loaded into counter");
	a_pc_even: assert property (@(posedge clk) disable iff (!resetn) booted |-> !program_counter_q[0])
		else $error("odd program counter");
	a_sp_even: assert property (@(posedge clk) disable iff (!resetn)
		(sp_push || sp_pop) && !reg_wr.we && !alu_write && !bit_store_carry
		|=> !low_q[stack_reg_index][0])
		else $error("stack pointer left odd");
endmodule

/* File: tb/vector_memory.sv */
`timescale 1ns/1ps
module vector_memory #(
	parameter int delay = 3,
	parameter logic [15:0] vector_word = 16'h1235
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// request
	input wire logic mem_req,
	input wire logic [15:0] mem_addr,
	// answer
	output logic [15:0] mem_rdata,
	output logic mem_rvalid
);
	int cnt;
	logic busy;
	// the vector request is a one-cycle pulse, so the model latches it and answers later
	// odd vector on purpose, so a counter that keeps bit zero shows up
	always_ff @(posedge clk) begin
		mem_rvalid <= 1'b0;
		if (!resetn) begin
			cnt <= 0;
			busy <= 1'b0;
		end else if (busy) begin
			cnt <= cnt + 1;
			if (cnt == delay) begin
				mem_rvalid <= 1'b1;
				busy <= 1'b0;
			end
		end else if (mem_req && mem_addr == 16'h0000) begin
			cnt <= 0;
			busy <= 1'b1;
		end
	end
	// data is scrambled whenever it is not valid
	assign mem_rdata = mem_rvalid ? vector_word : ~vector_word;
endmodule

/* File: tb/cpu_register_file_flags_tb_top.sv */
`timescale 1ns/1ps
module cpu_register_file_flags_tb_top;
	import cpu_regs_pkg::*;
	typedef struct {
		alu_op_t op;
		logic [15:0] a, b, res, rm;
		logic [7:0] c0, exp, cm;
	} row_t;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	reg_write_t reg_wr = '0;
	logic [2:0] rd_a_idx = '0, rd_b_idx = '0, alu_idx = '0, bit_sel = '0;
	logic rd_b_high = 1'b0, sp_push = 1'b0, sp_pop = 1'b0, pc_advance = 1'b0, pc_load = 1'b0;
	logic ccr_pop = 1'b0, exception_start = 1'b0, alu_write = 1'b0, mem_word = 1'b0;
	logic bit_load_carry = 1'b0, bit_store_carry = 1'b0;
	logic [15:0] pc_target = '0, ccr_pop_word = '0, alu_b = '0, mem_addr_in = '0, mem_rdata;
	logic [7:0] ccr_operand = '0, condition_code_register, rd_b_byte;
	logic [3:0] branch_cond = '0;
	ctl_op_t ccr_op = op_none;
	alu_op_t alu_op = alu_nop;
	logic mem_rvalid, mem_req, irq_masked, branch_taken, booted;
	logic [15:0] rd_a_word, stack_pointer, fetch_addr, mem_addr, ccr_push_word, e;
	logic [7:0] flags[4] = '{8'h04, 8'h0a, 8'h01, 8'h08};
	int fails = 0, num_checks = 0;
	// a, b, result, result mask, flags before, flags after, flag mask
	row_t rows[16] = '{
		'{alu_add_b, 16'h000f, 16'h0001, 16'h0010, 16'h00ff, 8'h00, 8'h20, 8'hff},
		'{alu_add_b, 16'h007f, 16'h0001, 16'h0080, 16'h00ff, 8'h00, 8'h2a, 8'hff},
		'{alu_add_b, 16'h00ff, 16'h0001, 16'h0000, 16'h00ff, 8'h00, 8'h25, 8'hff},
		'{alu_sub_b, 16'h0010, 16'h0001, 16'h000f, 16'h00ff, 8'h00, 8'h20, 8'hff},
		'{alu_cmp_b, 16'h0000, 16'h0001, 16'h0000, 16'hffff, 8'h00, 8'h29, 8'hff},
		'{alu_neg_b, 16'h0001, 16'h0000, 16'h00ff, 16'h00ff, 8'h00, 8'h29, 8'hff},
		'{alu_addx_b, 16'h00ff, 16'h0000, 16'h0000, 16'h00ff, 8'h05, 8'h25, 8'hff},
		'{alu_subx_b, 16'h0001, 16'h0000, 16'h0000, 16'h00ff, 8'h01, 8'h00, 8'hff},
		'{alu_add_w, 16'h0fff, 16'h0001, 16'h1000, 16'hffff, 8'h00, 8'h20, 8'hff},
		'{alu_sub_w, 16'h8000, 16'h0001, 16'h7fff, 16'hffff, 8'h00, 8'h22, 8'hff},
		'{alu_cmp_w, 16'h1234, 16'h1234, 16'h1234, 16'hffff, 8'h00, 8'h04, 8'hff},
		'{alu_shift_b, 16'h0081, 16'h0000, 16'h0002, 16'h00ff, 8'h70, 8'h71, 8'hff},
		'{alu_logic_b, 16'h00f0, 16'h000f, 16'h0000, 16'h00ff, 8'h51, 8'h55, 8'hff},
		'{alu_daa, 16'h000a, 16'h0000, 16'h0010, 16'h00ff, 8'h00, 8'h00, 8'hcd},
		'{alu_das, 16'h000c, 16'h0000, 16'h0006, 16'h00ff, 8'h20, 8'h20, 8'hcd},
		'{alu_xor_ccr, 16'h0000, 16'h00ff, 16'h0000, 16'h0000, 8'h0f, 8'hf0, 8'hff}
	};

	always #2 clk = ~clk;

	cpu_register_file_flags u_cpu_register_file_flags (.clk(clk), .resetn(resetn), .reg_wr(reg_wr),
		.rd_a_idx(rd_a_idx), .rd_b_idx(rd_b_idx), .rd_b_high(rd_b_high), .sp_push(sp_push),
		.sp_pop(sp_pop), .pc_advance(pc_advance), .pc_load(pc_load), .pc_target(pc_target),
		.ccr_op(ccr_op), .ccr_operand(ccr_operand), .ccr_pop(ccr_pop), .ccr_pop_word(ccr_pop_word),
		.exception_start(exception_start), .alu_op(alu_op), .alu_write(alu_write), .alu_idx(alu_idx),
		.alu_b(alu_b), .bit_sel(bit_sel), .bit_load_carry(bit_load_carry),
		.bit_store_carry(bit_store_carry), .branch_cond(branch_cond), .mem_addr_in(mem_addr_in),
		.mem_word(mem_word), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .rd_a_word(rd_a_word),
		.rd_b_byte(rd_b_byte), .stack_pointer(stack_pointer), .fetch_addr(fetch_addr),
		.mem_addr(mem_addr), .mem_req(mem_req), .condition_code_register(condition_code_register),
		.ccr_push_word(ccr_push_word), .irq_masked(irq_masked), .branch_taken(branch_taken),
		.booted(booted));
	vector_memory u_vector_memory (.clk(clk), .resetn(resetn), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));

	task automatic tick(int n = 1);
		repeat (n) @(posedge clk);
	endtask

	task automatic chk(logic [15:0] got, logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	// pulses drop one edge after they were raised, then outputs settle
	task automatic step();
		tick();
		reg_wr.we <= 1'b0;
		ccr_op <= op_none;
		alu_write <= 1'b0;
		sp_push <= 1'b0;
		sp_pop <= 1'b0;
		pc_advance <= 1'b0;
		pc_load <= 1'b0;
		ccr_pop <= 1'b0;
		exception_start <= 1'b0;
		bit_load_carry <= 1'b0;
		bit_store_carry <= 1'b0;
		#1;
	endtask

	task automatic boot();
		int n;
		n = 0;
		tick();
		resetn <= 1'b0;
		tick(11);
		#1;
		chk(mem_req, 16'h0000);
		chk(condition_code_register[7], 16'h0001);
		tick();
		resetn <= 1'b1;
		while (booted !== 1'b1 && n < 40) begin
			tick();
			#1;
			n++;
		end
		tick(2);
		#1;
		chk(fetch_addr, 16'h1234);
		chk(booted, 16'h0001);
		chk(irq_masked, 16'h0001);
	endtask

	task automatic run_row(row_t r);
		tick();
		reg_wr <= '{1'b1, 3'h1, 2'b11, r.a};
		ccr_op <= op_write;
		ccr_operand <= r.c0;
		step();
		tick();
		alu_op <= r.op;
		alu_write <= 1'b1;
		alu_idx <= 3'h1;
		alu_b <= r.b;
		rd_a_idx <= 3'h1;
		step();
		tick();
		#1;
		chk(condition_code_register & r.cm, r.exp & r.cm);
		chk(rd_a_word & r.rm, r.res & r.rm);
	endtask

	function automatic logic br(logic [3:0] c, logic [7:0] f);
		logic r;
		case (c[3:1])
			3'h0: r = 1'b1;
			3'h1: r = !(f[0] | f[2]);
			3'h2: r = !f[0];
			3'h3: r = !f[2];
			3'h4: r = !f[1];
			3'h5: r = !f[3];
			3'h6: r = !(f[3] ^ f[1]);
			default: r = !(f[2] | (f[3] ^ f[1]));
		endcase
		return c[0] ? !r : r;
	endfunction

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		final_report();
	end

	initial begin
		boot();
		foreach (rows[i]) run_row(rows[i]);
		for (int i = 0; i < 8; i++) begin
			tick();
			reg_wr <= '{1'b1, 3'(i), 2'b11, {8'(i), 8'(8'hf0 | i)}};
		end
		tick();
		reg_wr <= '{1'b1, 3'h3, 2'b10, 16'hab00};
		tick();
		reg_wr <= '{1'b1, 3'h4, 2'b01, 16'h00cd};
		step();
		for (int i = 0; i < 8; i++) begin
			e = {8'(i), 8'(8'hf0 | i)};
			if (i == 3)
				e[15:8] = 8'hab;
			if (i == 4)
				e[7:0] = 8'hcd;
			tick();
			rd_a_idx <= 3'(i);
			rd_b_idx <= 3'(i);
			rd_b_high <= i[0];
			tick();
			#1;
			chk(rd_a_word, e);
			chk(rd_b_byte, i[0] ? e[15:8] : e[7:0]);
		end
		tick();
		reg_wr <= '{1'b1, 3'h7, 2'b11, 16'h2000};
		step();
		tick();
		sp_push <= 1'b1;
		step();
		tick();
		#1;
		chk(stack_pointer, 16'h1ffe);
		tick();
		sp_pop <= 1'b1;
		step();
		tick();
		#1;
		chk(stack_pointer, 16'h2000);
		tick();
		pc_advance <= 1'b1;
		step();
		tick();
		#1;
		chk(fetch_addr, 16'h1236);
		tick();
		pc_load <= 1'b1;
		pc_target <= 16'h4567;
		step();
		tick();
		#1;
		chk(fetch_addr, 16'h4566);
		tick();
		mem_word <= 1'b1;
		mem_addr_in <= 16'h3333;
		step();
		chk(mem_addr, 16'h3332);
		tick();
		mem_word <= 1'b0;
		step();
		chk(mem_addr, 16'h3333);
		chk(mem_req, 16'h0001);
		tick();
		ccr_op <= op_write;
		ccr_operand <= 8'h3c;
		step();
		chk(condition_code_register, 16'h003c);
		tick();
		ccr_op <= op_and;
		ccr_operand <= 8'h0f;
		step();
		chk(condition_code_register, 16'h000c);
		tick();
		ccr_op <= op_or;
		ccr_operand <= 8'h40;
		step();
		chk(condition_code_register, 16'h004c);
		chk(ccr_push_word, 16'h4c4c);
		tick();
		ccr_pop <= 1'b1;
		ccr_pop_word <= 16'h1ee1;
		step();
		chk(condition_code_register, 16'h001e);
		tick();
		exception_start <= 1'b1;
		step();
		chk(condition_code_register, 16'h009e);
		tick();
		reg_wr <= '{1'b1, 3'h1, 2'b11, 16'h0020};
		ccr_op <= op_write;
		ccr_operand <= 8'h00;
		step();
		tick();
		bit_load_carry <= 1'b1;
		alu_idx <= 3'h1;
		bit_sel <= 3'h5;
		step();
		chk(condition_code_register, 16'h0001);
		tick();
		bit_store_carry <= 1'b1;
		bit_sel <= 3'h2;
		rd_a_idx <= 3'h1;
		step();
		tick();
		#1;
		chk(rd_a_word, 16'h0024);
		foreach (flags[j]) begin
			tick();
			ccr_op <= op_write;
			ccr_operand <= flags[j];
			step();
			for (int c = 0; c < 16; c++) begin
				tick();
				branch_cond <= 4'(c);
				step();
				chk(branch_taken, br(4'(c), flags[j]));
			end
		end
		// a second reset in mid-run must keep every flag except the mask
		tick();
		ccr_op <= op_write;
		ccr_operand <= 8'h50;
		step();
		boot();
		chk(condition_code_register, 16'h00d0);
		final_report();
	end
endmodule
